// *** fsr_fault_status.sv ***
// Behaviour
// R01: Bit 15 of status and mode words carries parity when enabled, else reserved; with parity off the mode word returns its stored, writable bit 15.
// R02: High-side over-current flags sit at bits 6, 5, 4 for phases C, B, A.
// R03: Low-side over-current flags sit at bits 2, 1, 0 for phases C, B, A.
// R04: Over-current flags self-clear on retry only in the automatic-retry modes.
// R05: Fault-clear write or sleep-pin reset pulse clears the over-current flags.
// R06: Interface status bit 4 flags a memory-load parity error.
// R07: Interface status bit 2 flags a serial frame parity error.
// R08: Interface status bit 1 flags serial bus contention.
// R09: Interface status bit 0 flags a malformed serial frame.
// R10: Interface status resets to all zeros.
// R11: Fault-mode register resets to 0015h.
// R12: Over-current mode picks slow retry, fast retry, latched Hi-Z or report only.
// R13: Serial error flags stay set until fault clear or sleep pulse; reads keep them.
`timescale 1ns/1ps
module fsr_fault_status
	import fsr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        sclkPin,
	input  wire logic        csPinN,
	input  wire logic        sdiPin,
	output wire logic        sdoData,
	output wire logic        sdoOe,
	input  wire logic        sleepInputN,
	input  wire logic [5:0]  ocEvt,
	input  wire logic        retryDone,
	input  wire logic        nvmLoadParityError,
	input  wire logic        serialContentionError,
	output wire logic [15:0] overcurrentStatus,
	output wire logic [15:0] interfaceErrorStatus,
	output wire logic [15:0] faultResponseConfig,
	output wire logic        serialParityEnable,
	output logic             faultClearControl,
	output logic             ocDriverHiZ,
	output logic             ocFaultReport
);

	// ==========================================================
	// Helpers
	function automatic logic [15:0] withParity(input logic [14:0] v, input logic en);
		withParity = {en & (^v), v};
	endfunction

	function automatic logic isAutoRetry(input logic [2:0] mode);
		isAutoRetry = (mode == FSR_OCP_SLOW) || (mode == FSR_OCP_FAST);
	endfunction

	// ==========================================================
	// Serial port
	fsr_frame_t     frame;
	fsr_frame_evt_t frameEvt;
	logic [5:0]     rdAddr;
	logic [15:0]    rdData;

	fsr_serial_frame fsr_serial_frame_inst (
		.mclk     (mclk),
		.nrst     (nrst),
		.sclkPin  (sclkPin),
		.csPinN   (csPinN),
		.sdiPin   (sdiPin),
		.rdData   (rdData),
		.rdAddr   (rdAddr),
		.frame    (frame),
		.frameEvt (frameEvt),
		.sdoData  (sdoData),
		.sdoOe    (sdoOe)
	);

	// ==========================================================
	// State
	logic [5:0]  ocFlag;
	logic [5:0]  next_ocFlag;
	logic        nvmErr;
	logic        parErr;
	logic        contErr;
	logic        frmErr;
	logic [15:0] fltMode;
	logic        parEn;
	logic [1:0]  sleepSync;
	logic        sleepPrev;
	logic        seenClk;

	// ==========================================================
	// Decode
	wire sleepPulse = sleepSync[1] & !sleepPrev;
	wire parityHit  = parEn & frameEvt.parityBad & !frameEvt.frameErr;
	wire frameOk    = frameEvt.done & !frameEvt.frameErr & !parityHit;
	wire wrOk       = frameOk & !frame.isRead;
	wire wrFltMode  = wrOk & (frame.addr == FSR_ADDR_FLTMODE);
	wire wrCtrl     = wrOk & (frame.addr == FSR_ADDR_CTRL);
	wire faultClear = wrCtrl & frame.data[FSR_CTRL_CLR_BIT];
	wire anyClear   = faultClear | sleepPulse; // R05
	wire [2:0] ocpMode = fltMode[FSR_OCP_LSB +: 3];
	wire ocClear    = anyClear | (isAutoRetry(ocpMode) & retryDone); // R04

	// Reads return live values and never disturb the sticky flags
	wire [14:0] ocRaw = {7'h0, 1'b0, ocFlag[5:3], 1'b0, ocFlag[2:0]}; // R02 R03
	wire [14:0] ifRaw = {10'h0, nvmErr, 1'b0, parErr, contErr, frmErr};
	wire [15:0] ocWord = withParity(ocRaw, parEn); // R01
	wire [15:0] ifWord = withParity(ifRaw, parEn); // R01
	wire [15:0] fmWord = parEn ? withParity(fltMode[14:0], 1'b1) : fltMode; // R01
	wire [15:0] ctWord = withParity({13'h0, parEn, 1'b0}, parEn);

	assign rdData = (rdAddr == FSR_ADDR_OCSTS)   ? ocWord :
	                (rdAddr == FSR_ADDR_IFSTS)   ? ifWord :
	                (rdAddr == FSR_ADDR_FLTMODE) ? fmWord :
	                (rdAddr == FSR_ADDR_CTRL)    ? ctWord : 16'h0000;

	assign overcurrentStatus    = ocWord;
	assign interfaceErrorStatus = ifWord;
	assign faultResponseConfig  = fltMode;
	assign serialParityEnable   = parEn;

	// ==========================================================
	// Over-current flags: set wins over any clear
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_oc
			assign next_ocFlag[gi] = ocEvt[gi] | (ocFlag[gi] & !ocClear); // R04 R05
		end
	endgenerate

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ocFlag <= 6'h0;
		end else begin
			ocFlag <= next_ocFlag;
		end
	end

	// ==========================================================
	// Interface error flags, sticky until cleared
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nvmErr  <= FSR_IFSTS_RST[FSR_IF_NVM_BIT]; // R10
			parErr  <= FSR_IFSTS_RST[FSR_IF_SPAR_BIT];
			contErr <= FSR_IFSTS_RST[FSR_IF_CONT_BIT];
			frmErr  <= FSR_IFSTS_RST[FSR_IF_FRM_BIT];
		end else begin
			nvmErr  <= nvmLoadParityError | (nvmErr & !anyClear); // R06 R13
			parErr  <= (frameEvt.done & parityHit) | (parErr & !anyClear); // R07 R13
			contErr <= serialContentionError | (contErr & !anyClear); // R08 R13
			frmErr  <= frameEvt.frameErr | (frmErr & !anyClear); // R09 R13
		end
	end

	// ==========================================================
	// Configuration and control
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fltMode           <= FSR_FLTMODE_RST; // R11
			parEn             <= FSR_PEN_RST;
			faultClearControl <= 1'h0;
		end else begin
			faultClearControl <= faultClear;
			if (wrFltMode) begin
				fltMode <= frame.data & FSR_FLTMODE_WMSK;
			end
			if (wrCtrl) begin
				parEn <= frame.data[FSR_CTRL_PEN_BIT];
			end
		end
	end

	// Reserved mode codes take no action on the driver
	always_comb begin
		ocDriverHiZ   = 1'b0;
		ocFaultReport = 1'b0;
		case (ocpMode)
			FSR_OCP_SLOW, FSR_OCP_FAST, FSR_OCP_LATCH: begin // R12
				ocDriverHiZ   = |ocFlag;
				ocFaultReport = |ocFlag;
			end
			FSR_OCP_REPORT: begin
				ocFaultReport = |ocFlag;
			end
			default: begin
				ocDriverHiZ   = 1'b0;
				ocFaultReport = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Sleep pin: clear fires on the wake edge of a low pulse
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sleepSync <= 2'h3;
			sleepPrev <= 1'h1;
			seenClk   <= 1'h0;
		end else begin
			sleepSync <= {sleepSync[0], sleepInputN};
			sleepPrev <= sleepSync[1];
			seenClk   <= 1'h1;
		end
	end

	// ==========================================================
	// Assertions
	property p_parity;
		@(posedge mclk) disable iff (!nrst)
		parEn |-> (^ocWord == 1'b0) && (^ifWord == 1'b0) && (^fmWord == 1'b0);
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong"); // R01

	property p_reserved15;
		@(posedge mclk) disable iff (!nrst)
		!parEn |-> !ocWord[15] && !ifWord[15];
	endproperty
	a_reserved15: assert property (p_reserved15) else $error("bit 15 set"); // R01

	property p_hs_set;
		@(posedge mclk) disable iff (!nrst)
		ocEvt[5:3] != 3'h0 |=> (overcurrentStatus[6:4] & $past(ocEvt[5:3])) == $past(ocEvt[5:3]);
	endproperty
	a_hs_set: assert property (p_hs_set) else $error("high-side flag lost"); // R02

	property p_ls_set;
		@(posedge mclk) disable iff (!nrst)
		ocEvt[2:0] != 3'h0 |=> (overcurrentStatus[2:0] & $past(ocEvt[2:0])) == $past(ocEvt[2:0]);
	endproperty
	a_ls_set: assert property (p_ls_set) else $error("low-side flag lost"); // R03

	property p_auto_clear;
		@(posedge mclk) disable iff (!nrst)
		retryDone && isAutoRetry(ocpMode) && ocEvt == 6'h0 |=> ocFlag == 6'h0;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("retry did not clear"); // R04

	property p_hold_latched;
		@(posedge mclk) disable iff (!nrst)
		!isAutoRetry(ocpMode) && !anyClear |=> (ocFlag & $past(ocFlag)) == $past(ocFlag);
	endproperty
	a_hold_latched: assert property (p_hold_latched) else $error("flag dropped"); // R04 R12

	property p_clear;
		@(posedge mclk) disable iff (!nrst)
		anyClear && ocEvt == 6'h0 && !nvmLoadParityError && !serialContentionError
			&& !frameEvt.frameErr && !parityHit
			|=> ocFlag == 6'h0 && ifRaw == 15'h0 && faultClearControl == $past(faultClear);
	endproperty
	a_clear: assert property (p_clear) else $error("clear ignored"); // R05

	property p_nvm;
		@(posedge mclk) disable iff (!nrst)
		nvmLoadParityError |=> interfaceErrorStatus[4];
	endproperty
	a_nvm: assert property (p_nvm) else $error("load error missing"); // R06

	property p_spar;
		@(posedge mclk) disable iff (!nrst)
		frameEvt.done && parityHit |=> interfaceErrorStatus[2] && $stable(fltMode);
	endproperty
	a_spar: assert property (p_spar) else $error("parity error missing"); // R07

	property p_cont;
		@(posedge mclk) disable iff (!nrst)
		serialContentionError |=> interfaceErrorStatus[1];
	endproperty
	a_cont: assert property (p_cont) else $error("contention missing"); // R08

	property p_frm;
		@(posedge mclk) disable iff (!nrst)
		frameEvt.frameErr |=> interfaceErrorStatus[0] && $stable(parEn);
	endproperty
	a_frm: assert property (p_frm) else $error("frame error missing"); // R09

	property p_reset_vals;
		@(posedge mclk) disable iff (!nrst)
		!seenClk |-> ifRaw == 15'h0 && fltMode == 16'h0015;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // R10 R11

	property p_sticky;
		@(posedge mclk) disable iff (!nrst)
		!anyClear |=> (ifRaw & $past(ifRaw)) == $past(ifRaw);
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag dropped"); // R13

	property p_latch_hiz;
		@(posedge mclk) disable iff (!nrst)
		ocpMode == FSR_OCP_LATCH && ocFlag != 6'h0 |-> ocDriverHiZ && ocFaultReport;
	endproperty
	a_latch_hiz: assert property (p_latch_hiz) else $error("latched mode not Hi-Z"); // R12

	property p_report_only;
		@(posedge mclk) disable iff (!nrst)
		ocpMode == FSR_OCP_REPORT |-> !ocDriverHiZ && ocFaultReport == (ocFlag != 6'h0);
	endproperty
	a_report_only: assert property (p_report_only) else $error("report mode wrong"); // R12

	property p_reserved_mode;
		@(posedge mclk) disable iff (!nrst)
		ocpMode[2] |-> !ocDriverHiZ && !ocFaultReport;
	endproperty
	a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode acts"); // R12

	property p_oc_reserved_bits;
		@(posedge mclk) disable iff (!nrst)
		overcurrentStatus[14:7] == 8'h0 && !overcurrentStatus[3];
	endproperty
	a_oc_reserved_bits: assert property (p_oc_reserved_bits) else $error("oc reserved set"); // R02 R03

	property p_clear_pulse;
		@(posedge mclk) disable iff (!nrst)
		faultClearControl |=> !faultClearControl;
	endproperty
	a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long"); // R05

endmodule

// *** fsr_fault_status_tb.sv ***
`timescale 1ns/1ps
module fsr_fault_status_tb import fsr_pkg::*;;
	logic        mclk, nrst, sclkPin, csPinN, sdiPin, sdoData, sdoOe, sleepInputN;
	logic        retryDone, nvmLoadParityError, serialContentionError, serialParityEnable;
	logic        faultClearControl, ocDriverHiZ, ocFaultReport;
	logic [5:0]  ocEvt;
	logic [15:0] overcurrentStatus, interfaceErrorStatus, faultResponseConfig;
	int          errorCnt, comparisons;

	fsr_fault_status fsr_fault_status_inst (.mclk(mclk), .nrst(nrst), .sclkPin(sclkPin),
		.csPinN(csPinN), .sdiPin(sdiPin), .sdoData(sdoData), .sdoOe(sdoOe),
		.sleepInputN(sleepInputN), .ocEvt(ocEvt), .retryDone(retryDone),
		.nvmLoadParityError(nvmLoadParityError), .serialContentionError(serialContentionError),
		.overcurrentStatus(overcurrentStatus), .interfaceErrorStatus(interfaceErrorStatus),
		.faultResponseConfig(faultResponseConfig), .serialParityEnable(serialParityEnable),
		.faultClearControl(faultClearControl), .ocDriverHiZ(ocDriverHiZ),
		.ocFaultReport(ocFaultReport));
	fsr_spi_host fsr_spi_host_inst (.mclk(mclk), .sclkPin(sclkPin), .csPinN(csPinN),
		.sdiPin(sdiPin), .sdoData(sdoData));

	// ====================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	function automatic logic [23:0] mk(input logic r, input logic [5:0] a, input logic [15:0] d,
		input logic pen);
		logic [23:0] f;
		f = {r, a, 1'b0, d};
		f[16] = pen & (^f);
		return f;
	endfunction

	task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic pen);
		logic [15:0] r;
		fsr_spi_host_inst.xfer(mk(1'b0, a, d, pen), 24, r);
		repeat (8) @(posedge mclk);
	endtask

	task automatic rd(input logic [5:0] a, input logic pen, output logic [15:0] r);
		fsr_spi_host_inst.xfer(mk(1'b1, a, 16'h0000, pen), 24, r);
		repeat (8) @(posedge mclk);
	endtask

	task automatic oc(input logic [5:0] v);
		ocEvt <= v;
		@(posedge mclk);
		ocEvt <= 6'h00;
		repeat (2) @(posedge mclk);
	endtask

	task automatic fclear();
		logic [15:0] r;
		int n;
		n = 0;
		fsr_spi_host_inst.xfer(mk(1'b0, FSR_ADDR_CTRL, 16'h0001, 1'b0), 24, r);
		repeat (14) begin
			@(posedge mclk);
			n += int'(faultClearControl === 1'b1);
		end
		chk("clear pulse count", 16'h0001, 16'(n));
	endtask

	// ====================
	// Scenarios
	task automatic t_reset();
		logic [15:0] r;
		chk("ifsts port", 16'h0000, interfaceErrorStatus);
		chk("fltmode port", 16'h0015, faultResponseConfig);
		chk("sdo idle", 16'h0000, 16'(sdoOe));
		rd(FSR_ADDR_IFSTS, 1'b0, r);
		chk("ifsts read", 16'h0000, r);
		rd(FSR_ADDR_FLTMODE, 1'b0, r);
		chk("fltmode read", 16'h0015, r);
		$display("test reset done");
	endtask

	task automatic t_ocmap();
		logic [15:0] pos [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0040};
		logic [15:0] r;
		for (int i = 0; i < 6; i++) begin
			oc(6'(1 << i));
			chk("oc flag", pos[i], overcurrentStatus);
			fclear();
			chk("oc cleared", 16'h0000, overcurrentStatus);
		end
		oc(6'h3f);
		rd(FSR_ADDR_OCSTS, 1'b0, r);
		chk("oc read", 16'h0077, r);
		fclear();
		$display("test flag map done");
	endtask

	task automatic t_retry();
		for (int m = 0; m < 5; m++) begin
			wr(FSR_ADDR_FLTMODE, 16'h0005 | 16'(m << 4), 1'b0);
			chk("mode", 16'h0005 | 16'(m << 4), faultResponseConfig);
			oc(6'h08);
			chk("hiz", 16'(m < 3), 16'(ocDriverHiZ));
			chk("report", 16'(m < 4), 16'(ocFaultReport));
			retryDone <= 1'b1;
			@(posedge mclk);
			retryDone <= 1'b0;
			repeat (2) @(posedge mclk);
			chk("after retry", (m < 2) ? 16'h0000 : 16'h0010, overcurrentStatus);
			fclear();
		end
		wr(FSR_ADDR_FLTMODE, 16'h0015, 1'b0);
		$display("test retry modes done");
	endtask

	task automatic t_iferr();
		logic [15:0] r;
		nvmLoadParityError <= 1'b1;
		serialContentionError <= 1'b1;
		@(posedge mclk);
		nvmLoadParityError <= 1'b0;
		serialContentionError <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("nvm and bus", 16'h0012, interfaceErrorStatus);
		fsr_spi_host_inst.xfer(mk(1'b0, FSR_ADDR_FLTMODE, 16'h0000, 1'b0), 23, r);
		repeat (8) @(posedge mclk);
		chk("frame error", 16'h0013, interfaceErrorStatus);
		chk("short no write", 16'h0015, faultResponseConfig);
		wr(FSR_ADDR_CTRL, 16'h0002, 1'b0);
		chk("parity on", 16'h0001, 16'(serialParityEnable));
		fsr_spi_host_inst.xfer(mk(1'b0, FSR_ADDR_FLTMODE, 16'h0000, 1'b1) ^ 24'h010000, 24, r);
		repeat (8) @(posedge mclk);
		chk("parity error", 16'h0017, interfaceErrorStatus);
		rd(FSR_ADDR_FLTMODE, 1'b1, r);
		chk("read parity bit", 16'h8015, r);
		rd(FSR_ADDR_IFSTS, 1'b1, r);
		chk("sticky read", 16'h0017, r);
		chk("sticky port", 16'h0017, interfaceErrorStatus);
		oc(6'h01);
		sleepInputN <= 1'b0;
		repeat (4) @(posedge mclk);
		sleepInputN <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("sleep ifsts", 16'h0000, interfaceErrorStatus);
		chk("sleep oc", 16'h0000, overcurrentStatus);
		wr(FSR_ADDR_CTRL, 16'h0000, 1'b1);
		chk("parity off", 16'h0000, 16'(serialParityEnable));
		$display("test interface errors done");
	endtask

	task automatic giveVerdict();
		$display("comparisons %0d mismatches %0d", comparisons, errorCnt);
		if (errorCnt == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ====================
	// Sequence
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		repeat (100000) @(posedge mclk);
		errorCnt++;
		giveVerdict();
	end

	initial begin
		nrst = 1'b0;
		sleepInputN = 1'b1;
		ocEvt = 6'h00;
		retryDone = 1'b0;
		nvmLoadParityError = 1'b0;
		serialContentionError = 1'b0;
		errorCnt = 0;
		comparisons = 0;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_ocmap();
		t_retry();
		t_iferr();
		giveVerdict();
	end
endmodule

// *** fsr_pkg.sv ***
package fsr_pkg;

	// ==========================================================
	// Register offsets (6-bit serial address)
	localparam logic [5:0]  FSR_ADDR_OCSTS   = 6'h06;
	localparam logic [5:0]  FSR_ADDR_IFSTS   = 6'h07;
	localparam logic [5:0]  FSR_ADDR_FLTMODE = 6'h10;
	localparam logic [5:0]  FSR_ADDR_CTRL    = 6'h20;

	// ==========================================================
	// Field positions
	localparam int          FSR_PARITY_BIT   = 15;
	localparam int          FSR_OC_HS_LSB    = 4;
	localparam int          FSR_OC_LS_LSB    = 0;
	localparam int          FSR_IF_NVM_BIT   = 4;
	localparam int          FSR_IF_SPAR_BIT  = 2;
	localparam int          FSR_IF_CONT_BIT  = 1;
	localparam int          FSR_IF_FRM_BIT   = 0;
	localparam int          FSR_OCP_LSB      = 4;
	localparam int          FSR_CTRL_CLR_BIT = 0;
	localparam int          FSR_CTRL_PEN_BIT = 1;

	// ==========================================================
	// Reset values and write masks
	localparam logic [15:0] FSR_IFSTS_RST    = 16'h0000;
	localparam logic [15:0] FSR_FLTMODE_RST  = 16'h0015;
	localparam logic [15:0] FSR_FLTMODE_WMSK = 16'h9fff;
	localparam logic        FSR_PEN_RST      = 1'h0;

	// ==========================================================
	// Serial frame geometry
	localparam logic [4:0]  FSR_FRAME_BITS   = 5'h18;
	localparam logic [4:0]  FSR_HDR_BITS     = 5'h08;

	typedef enum logic [2:0] {
		FSR_OCP_SLOW   = 3'h0,
		FSR_OCP_FAST   = 3'h1,
		FSR_OCP_LATCH  = 3'h2,
		FSR_OCP_REPORT = 3'h3
	} fsr_overcurrent_response_select_t;

	typedef struct packed {
		logic       isRead;
		logic [5:0] addr;
		logic       parBit;
		logic [15:0] data;
	} fsr_frame_t;

	typedef struct packed {
		logic done;
		logic frameErr;
		logic parityBad;
	} fsr_frame_evt_t;

endpackage

// *** fsr_serial_frame.sv ***
`timescale 1ns/1ps
module fsr_serial_frame
	import fsr_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           nrst,
	input  wire logic           sclkPin,
	input  wire logic           csPinN,
	input  wire logic           sdiPin,
	input  wire logic [15:0]    rdData,
	output wire logic [5:0]     rdAddr,
	output fsr_frame_t          frame,
	output fsr_frame_evt_t      frameEvt,
	output wire logic           sdoData,
	output wire logic           sdoOe
);

	// ==========================================================
	// Pin synchronisers
	logic [1:0]  sclkSync;
	logic [1:0]  csSync;
	logic [1:0]  sdiSync;
	logic        sclkPrev;
	logic        csPrevActive;
	logic [4:0]  bitCnt;
	logic [23:0] rxShift;
	logic [15:0] txShift;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclkSync <= 2'h0;
			csSync   <= 2'h3;
			sdiSync  <= 2'h0;
		end else begin
			sclkSync <= {sclkSync[0], sclkPin};
			csSync   <= {csSync[0], csPinN};
			sdiSync  <= {sdiSync[0], sdiPin};
		end
	end

	wire csActive = !csSync[1];
	wire sclkRise = sclkSync[1] & !sclkPrev;
	wire sclkFall = !sclkSync[1] & sclkPrev;
	wire csStart  = csActive & !csPrevActive;
	wire csEnd    = !csActive & csPrevActive;

	assign rdAddr  = rxShift[6:1];
	assign sdoData = txShift[15];
	assign sdoOe   = csActive;

	// ==========================================================
	// Shift engine: sample on rising, launch on falling edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclkPrev     <= 1'h0;
			csPrevActive <= 1'h0;
			bitCnt       <= 5'h0;
			rxShift      <= 24'h0;
			txShift      <= 16'h0;
		end else begin
			sclkPrev     <= sclkSync[1];
			csPrevActive <= csActive;
			if (csStart) begin
				bitCnt  <= 5'h0;
				txShift <= 16'h0;
			end else if (csActive && sclkRise) begin
				rxShift <= {rxShift[22:0], sdiSync[1]};
				// Saturate so long frames still count as malformed
				if (bitCnt != 5'h1f) begin
					bitCnt <= bitCnt + 5'h1;
				end
			end else if (csActive && sclkFall) begin
				if (bitCnt == FSR_HDR_BITS) begin
					txShift <= rdData;
				end else begin
					txShift <= {txShift[14:0], 1'b0};
				end
			end
		end
	end

	// ==========================================================
	// Frame completion
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			frame    <= '0;
			frameEvt <= '0;
		end else begin
			frameEvt.done      <= csEnd;
			frameEvt.frameErr  <= csEnd & (bitCnt != FSR_FRAME_BITS);
			frameEvt.parityBad <= csEnd & (^rxShift);
			if (csEnd) begin
				frame <= rxShift;
			end
		end
	end

endmodule

// *** fsr_spi_host.sv ***
`timescale 1ns/1ps
module fsr_spi_host
	import fsr_pkg::*;
(
	input  wire logic mclk,
	output logic      sclkPin,
	output logic      csPinN,
	output logic      sdiPin,
	input  wire logic sdoData
);
	// ====================
	// Mode 0 host
	initial begin
		sclkPin = 1'b0;
		csPinN  = 1'b1;
		sdiPin  = 1'b0;
	end

	// Five mclk between pin changes (5 high, 10 low per bit) keeps clear of the two-flop synchronisers
	task automatic xfer(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		csPinN <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			repeat (5) @(posedge mclk);
			sdiPin <= tx[23-i];
			repeat (5) @(posedge mclk);
			sclkPin <= 1'b1;
			rx = {rx[14:0], sdoData};
			repeat (5) @(posedge mclk);
			sclkPin <= 1'b0;
		end
		repeat (5) @(posedge mclk);
		csPinN <= 1'b1;
		// Released data line must not keep its last value
		sdiPin <= ~sdiPin;
		@(posedge mclk);
	endtask
endmodule
